// file: uemr_cfg.svh
`ifndef UEMR_CFG_SVH
`define UEMR_CFG_SVH
// endpoint mode encodings
`define UEMR_M_DISABLE   4'h0
`define UEMR_M_NAK_INOUT 4'h1
`define UEMR_M_STS_OUT   4'h2
`define UEMR_M_STALL_IO  4'h3
`define UEMR_M_IGN_IO    4'h4
`define UEMR_M_RSV5      4'h5
`define UEMR_M_STS_IN    4'h6
`define UEMR_M_RSV7      4'h7
`define UEMR_M_NAK_OUT   4'h8
`define UEMR_M_ACK_OUT   4'h9
`define UEMR_M_NAKO_STI  4'hA
`define UEMR_M_ACKO_NAKI 4'hB
`define UEMR_M_NAK_IN    4'hC
`define UEMR_M_ACK_IN    4'hD
`define UEMR_M_NAKI_STO  4'hE
`define UEMR_M_ACKI_STO  4'hF
// register map (word index on the plain port)
`define UEMR_A_MODE0     4'h0
`define UEMR_A_CNT0      4'h1
`define UEMR_A_MODE1     4'h2
`define UEMR_A_CNT1      4'h3
`define UEMR_A_STATUS    4'h4
// field positions
`define UEMR_STALL_BIT   7
`define UEMR_ST_SETUP    0
`define UEMR_ST_IN       1
`define UEMR_ST_OUT      2
`define UEMR_ST_ACK      3
`define UEMR_ST_LOCK     4
`define UEMR_ST_TOGGLE   5
// crc bytes added to endpoint size
`define UEMR_CRC_BYTES   5'h02
`define UEMR_ZERO8       8'h00
`endif

// file: uemr_pkg.sv
package uemr_pkg;
  typedef enum logic [1:0] {
    UEMR_TOK_SETUP,
    UEMR_TOK_IN,
    UEMR_TOK_OUT
  } uemr_tok_t;

  typedef enum logic [2:0] {
    UEMR_RSP_NONE,
    UEMR_RSP_ACK,
    UEMR_RSP_NAK,
    UEMR_RSP_STALL,
    UEMR_RSP_TXCNT,
    UEMR_RSP_TX0
  } uemr_rsp_t;

  // token from the line decoder
  typedef struct packed {
    logic      ep;
    uemr_tok_t tok;
  } uemr_token_t;

  // end of the data phase of setup/out
  typedef struct packed {
    logic [4:0] count;
    logic       toggle;
    logic       crc_ok;
    logic       err_ok;
  } uemr_data_t;

  // answer to the line encoder
  typedef struct packed {
    logic       valid;
    uemr_rsp_t  rsp;
    logic [3:0] count;
    logic       toggle;
  } uemr_answer_t;
endpackage

// file: uemr_responder.sv
`timescale 1ns/10ps
`include "uemr_cfg.svh"
// Behaviour
// RULE1: each endpoint keeps a four-bit mode choosing answers to SETUP, IN, OUT.
// RULE2: mode 0001 acknowledges SETUP and NAKs every IN and OUT.
// RULE3: status check ACKs only zero-length toggle-1 OUT, else STALL or ignore.
// RULE4: counted transmit sends the byte count held in the count register.
// RULE5: zero-byte transmit mode answers IN with an empty data packet.
// RULE6: ignore answers send no handshake at all.
// RULE7: a mode accepting SETUP ACKs every valid SETUP.
// RULE8: ACKed status OUT in mode 1111 rewrites the mode to 1110.
// RULE9: SETUP to an enabled accepting endpoint sets its mode to 0001.
// RULE10: modes reset to 0000; disabled stays disabled until firmware writes.
// RULE11: control endpoint flags whether the token was SETUP, IN or OUT.
// RULE12: invalid transactions get no answer.
// RULE13: interrupt on valid completion and on bad-CRC buffer corruption.
// RULE14: data valid only if count within size plus two and checks pass.
// RULE15: OUT-only modes ignore IN, IN-only modes ignore OUT.
// RULE16: IN and OUT status bits update at transaction end.
// RULE17: SETUP status bit updates when its data phase begins.
// RULE18: ACK on control endpoint locks mode and count until CPU reads.
// RULE19: firmware reads the mode register first in each endpoint handler.
// RULE20: firmware never gives the non-control endpoint a SETUP-accepting mode.
// RULE21: firmware rewrites the mode after the engine changes it.
// RULE22: non-control bit 7 stall turns ACK/data answers into STALL.
// RULE23: mode 1001 after ACKed OUT becomes 1000.
// RULE24: mode 1101 after ACKed IN becomes 1100.
// RULE25: mode 1011 after ACKed OUT becomes 0001.
// RULE26: engine mode update beats a same-cycle CPU write and locks; the code locks only for endpoint 0.
module uemr_responder #(
  parameter int EP_SIZE = 8
) (
  // clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  reset_n_i,
  // register port
  input  wire logic [3:0]            reg_addr_i,
  input  wire logic [7:0]            reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [7:0]            reg_rdata_o,
  // packet engine side
  input  wire logic                  token_valid_i,
  input  uemr_pkg::uemr_token_t      token_i,
  input  wire logic                  data_start_i,
  input  wire logic                  data_done_i,
  input  uemr_pkg::uemr_data_t       data_i,
  input  wire logic                  host_ack_i,
  input  wire logic                  host_timeout_i,
  output uemr_pkg::uemr_answer_t     answer_o,
  output logic                       irq_o
);

  // ******************************************
  // state
  // ******************************************
  typedef enum logic [1:0] {
    UEMR_S_IDLE,
    UEMR_S_DATA,
    UEMR_S_WAIT_HS
  } uemr_state_t;

  uemr_state_t               state, next_state;
  logic [7:0]                mode [2];
  logic [7:0]                next_mode [2];
  logic [3:0]                cnt [2];
  logic [3:0]                next_cnt [2];
  logic [5:0]                status, next_status;
  logic                      ep, next_ep;
  uemr_pkg::uemr_tok_t       tok, next_tok;
  uemr_pkg::uemr_answer_t    next_answer;
  logic [7:0]                next_rdata;
  logic                      next_irq;
  logic                      lock, next_lock;
  logic                      rd_mode0;

  // ******************************************
  // mode decode
  // ******************************************
  function automatic uemr_pkg::uemr_rsp_t in_rsp(input logic [3:0] m, input logic stall);
    uemr_pkg::uemr_rsp_t r;
    r = uemr_pkg::UEMR_RSP_NONE;
    case (m)
      `UEMR_M_NAK_INOUT, `UEMR_M_ACKO_NAKI,
      `UEMR_M_NAK_IN, `UEMR_M_NAKI_STO:   r = uemr_pkg::UEMR_RSP_NAK; // RULE2
      `UEMR_M_STS_OUT, `UEMR_M_STALL_IO:  r = uemr_pkg::UEMR_RSP_STALL;
      `UEMR_M_STS_IN, `UEMR_M_NAKO_STI:   r = uemr_pkg::UEMR_RSP_TX0; // RULE5
      `UEMR_M_RSV7, `UEMR_M_ACKI_STO:     r = uemr_pkg::UEMR_RSP_TXCNT; // RULE4
      `UEMR_M_ACK_IN:                     r = stall ? uemr_pkg::UEMR_RSP_STALL
                                                    : uemr_pkg::UEMR_RSP_TXCNT; // RULE22
      default:                            r = uemr_pkg::UEMR_RSP_NONE; // RULE6 RULE15
    endcase
    return r;
  endfunction

  // out answer; 'check' modes need zero length with toggle 1
  function automatic uemr_pkg::uemr_rsp_t out_rsp(input logic [3:0] m, input logic stall,
                                                 input logic zero_t1);
    uemr_pkg::uemr_rsp_t r;
    r = uemr_pkg::UEMR_RSP_NONE;
    case (m)
      `UEMR_M_NAK_INOUT, `UEMR_M_NAK_OUT,
      `UEMR_M_NAKO_STI:                   r = uemr_pkg::UEMR_RSP_NAK; // RULE2
      `UEMR_M_STALL_IO, `UEMR_M_STS_IN:   r = uemr_pkg::UEMR_RSP_STALL;
      `UEMR_M_RSV5, `UEMR_M_ACKO_NAKI:    r = uemr_pkg::UEMR_RSP_ACK;
      `UEMR_M_ACK_OUT:                    r = stall ? uemr_pkg::UEMR_RSP_STALL
                                                    : uemr_pkg::UEMR_RSP_ACK; // RULE22
      `UEMR_M_STS_OUT, `UEMR_M_NAKI_STO,
      `UEMR_M_ACKI_STO:                   r = zero_t1 ? uemr_pkg::UEMR_RSP_ACK
                                                      : uemr_pkg::UEMR_RSP_STALL; // RULE3
      default:                            r = uemr_pkg::UEMR_RSP_NONE; // RULE15
    endcase
    return r;
  endfunction

  function automatic logic takes_setup(input logic [3:0] m);
    case (m)
      `UEMR_M_NAK_INOUT, `UEMR_M_STS_OUT, `UEMR_M_STALL_IO, `UEMR_M_IGN_IO,
      `UEMR_M_STS_IN, `UEMR_M_NAKO_STI, `UEMR_M_ACKO_NAKI,
      `UEMR_M_NAKI_STO, `UEMR_M_ACKI_STO: return 1'b1;
      default:                            return 1'b0;
    endcase
  endfunction

  // ******************************************
  // next-state logic
  // ******************************************
  logic       data_ok;
  logic       zero_t1;
  logic [3:0] cur_mode;
  logic       cur_stall;
  uemr_pkg::uemr_rsp_t rsp_out;
  uemr_pkg::uemr_rsp_t rsp_in;

  always_comb begin
    cur_mode  = mode[ep][3:0]; // RULE1
    cur_stall = ep & mode[ep][`UEMR_STALL_BIT];
    data_ok   = data_i.crc_ok && data_i.err_ok &&
                (data_i.count <= 5'(EP_SIZE) + `UEMR_CRC_BYTES); // RULE14
    zero_t1   = (data_i.count == `UEMR_CRC_BYTES) && data_i.toggle;
    rsp_out   = out_rsp(cur_mode, cur_stall, zero_t1);
    rsp_in    = in_rsp(mode[token_i.ep][3:0], token_i.ep & mode[token_i.ep][`UEMR_STALL_BIT]);
    rd_mode0  = reg_rd_i && (reg_addr_i == `UEMR_A_MODE0 || reg_addr_i == `UEMR_A_CNT0);
    next_state  = state;
    next_ep     = ep;
    next_tok    = tok;
    next_mode   = mode;
    next_cnt    = cnt;
    next_status = status;
    next_lock   = lock;
    next_irq    = 1'b0;
    next_answer = '0;
    next_answer.count  = cnt[ep];
    next_answer.toggle = status[`UEMR_ST_TOGGLE];
    // cpu side; a read of MODE0 or CNT0 unlocks only once the engine is idle
    if (rd_mode0 && state == UEMR_S_IDLE) begin
      next_lock = 1'b0; // RULE18
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        `UEMR_A_MODE0: if (!lock) next_mode[0] = reg_wdata_i; // RULE18 RULE10
        `UEMR_A_CNT0:  if (!lock) next_cnt[0] = reg_wdata_i[3:0]; // RULE18
        `UEMR_A_MODE1: next_mode[1] = reg_wdata_i;
        `UEMR_A_CNT1:  next_cnt[1] = reg_wdata_i[3:0];
        default: ;
      endcase
    end
    // engine side, placed after cpu so it wins
    case (state)
      UEMR_S_IDLE: begin
        if (token_valid_i) begin
          next_ep  = token_i.ep;
          next_tok = token_i.tok;
          if (token_i.tok == uemr_pkg::UEMR_TOK_IN) begin
            next_answer.valid = (rsp_in != uemr_pkg::UEMR_RSP_NONE); // RULE6
            next_answer.rsp   = rsp_in;
            next_answer.count = (rsp_in == uemr_pkg::UEMR_RSP_TX0) ? 4'h0 : cnt[token_i.ep]; // RULE4 RULE5
            if (rsp_in == uemr_pkg::UEMR_RSP_TXCNT || rsp_in == uemr_pkg::UEMR_RSP_TX0) begin
              next_state = UEMR_S_WAIT_HS;
            end else if (rsp_in != uemr_pkg::UEMR_RSP_NONE) begin
              next_irq = 1'b1; // RULE13
              if (!token_i.ep) next_status[`UEMR_ST_IN] = 1'b1; // RULE16 RULE11
            end
          end else begin
            next_state = UEMR_S_DATA;
          end
        end
      end
      UEMR_S_DATA: begin
        if (data_start_i && tok == uemr_pkg::UEMR_TOK_SETUP && takes_setup(cur_mode) && !ep) begin
          next_status[`UEMR_ST_SETUP] = 1'b1; // RULE17 RULE11
          next_status[`UEMR_ST_IN]    = 1'b0;
          next_status[`UEMR_ST_OUT]   = 1'b0;
        end
        if (data_done_i) begin
          next_state = UEMR_S_IDLE;
          if (!data_ok) begin
            // corrupted buffer raises irq only when the address accepted data
            next_irq = data_i.crc_ok ? 1'b0 :
                       (tok == uemr_pkg::UEMR_TOK_SETUP ? takes_setup(cur_mode)
                                                        : rsp_out == uemr_pkg::UEMR_RSP_ACK); // RULE13 RULE12
          end else if (tok == uemr_pkg::UEMR_TOK_SETUP) begin
            if (takes_setup(cur_mode)) begin
              next_answer.valid = 1'b1;
              next_answer.rsp   = uemr_pkg::UEMR_RSP_ACK; // RULE7
              next_mode[ep]     = {mode[ep][7:4], `UEMR_M_NAK_INOUT}; // RULE9 RULE26
              next_status[`UEMR_ST_TOGGLE] = data_i.toggle;
              next_status[`UEMR_ST_ACK]    = 1'b1;
              next_irq = 1'b1;
              if (!ep) next_lock = 1'b1; // RULE18
            end
          end else if (rsp_out != uemr_pkg::UEMR_RSP_NONE) begin
            next_answer.valid = 1'b1;
            next_answer.rsp   = rsp_out;
            next_irq          = 1'b1; // RULE13
            if (!ep) next_status[`UEMR_ST_OUT] = 1'b1; // RULE16
            if (rsp_out == uemr_pkg::UEMR_RSP_ACK) begin
              next_status[`UEMR_ST_ACK]    = 1'b1;
              next_status[`UEMR_ST_TOGGLE] = data_i.toggle;
              if (!ep) next_lock = 1'b1; // RULE18 RULE26
              case (cur_mode)
                `UEMR_M_ACKI_STO:  next_mode[ep] = {mode[ep][7:4], `UEMR_M_NAKI_STO}; // RULE8
                `UEMR_M_ACK_OUT:   next_mode[ep] = {mode[ep][7:4], `UEMR_M_NAK_OUT}; // RULE23
                `UEMR_M_ACKO_NAKI: next_mode[ep] = {mode[ep][7:4], `UEMR_M_NAK_INOUT}; // RULE25
                default: ;
              endcase
            end
          end
        end
      end
      UEMR_S_WAIT_HS: begin
        if (host_ack_i || host_timeout_i) begin
          next_state = UEMR_S_IDLE;
          next_irq   = 1'b1; // RULE13
          if (!ep) next_status[`UEMR_ST_IN] = 1'b1; // RULE16
          if (host_ack_i) begin
            next_status[`UEMR_ST_ACK] = 1'b1;
            if (!ep) next_lock = 1'b1; // RULE18
            if (cur_mode == `UEMR_M_ACK_IN) next_mode[ep] = {mode[ep][7:4], `UEMR_M_NAK_IN}; // RULE24
            if (cur_mode == `UEMR_M_ACKI_STO) next_mode[ep] = {mode[ep][7:4], `UEMR_M_NAKI_STO};
          end
        end
      end
      default: next_state = UEMR_S_IDLE;
    endcase
    // read data
    case (reg_addr_i)
      `UEMR_A_MODE0:  next_rdata = mode[0];
      `UEMR_A_CNT0:   next_rdata = {4'h0, cnt[0]};
      `UEMR_A_MODE1:  next_rdata = mode[1];
      `UEMR_A_CNT1:   next_rdata = {4'h0, cnt[1]};
      `UEMR_A_STATUS: next_rdata = {2'h0, status};
      default:        next_rdata = `UEMR_ZERO8;
    endcase
    if (!reg_rd_i) next_rdata = `UEMR_ZERO8;
    next_status[`UEMR_ST_LOCK] = next_lock;
  end

  // ******************************************
  // registers
  // ******************************************
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state       <= UEMR_S_IDLE;
      mode[0]     <= `UEMR_ZERO8; // RULE10
      mode[1]     <= `UEMR_ZERO8;
      cnt[0]      <= 4'h0;
      cnt[1]      <= 4'h0;
      status      <= 6'h00;
      ep          <= 1'b0;
      tok         <= uemr_pkg::UEMR_TOK_SETUP;
      lock        <= 1'b0;
      answer_o    <= '0;
      reg_rdata_o <= `UEMR_ZERO8;
      irq_o       <= 1'b0;
    end else begin
      state       <= next_state;
      mode        <= next_mode;
      cnt         <= next_cnt;
      status      <= next_status;
      ep          <= next_ep;
      tok         <= next_tok;
      lock        <= next_lock;
      answer_o    <= next_answer;
      reg_rdata_o <= next_rdata;
      irq_o       <= next_irq;
    end
  end

  // ******************************************
  // checks
  // ******************************************
  AST_RESET_DISABLED: assert property (@(posedge clock_i) !reset_n_i |=> mode[0] == `UEMR_ZERO8) // RULE10
    else $error("mode not cleared by reset");
  AST_LOCK_BLOCKS: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RULE18
    lock && reg_wr_i && reg_addr_i == `UEMR_A_MODE0 && state == UEMR_S_IDLE && !token_valid_i
    |=> $stable(mode[0]))
    else $error("locked mode register took a write");
  AST_MODE1_NAK: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RULE2
    state == UEMR_S_IDLE && token_valid_i && token_i.tok == uemr_pkg::UEMR_TOK_IN &&
    mode[token_i.ep][3:0] == `UEMR_M_NAK_INOUT |=> answer_o.valid && answer_o.rsp == uemr_pkg::UEMR_RSP_NAK)
    else $error("mode 0001 did not nak in");
  AST_DISABLED_SILENT: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RULE6
    state == UEMR_S_IDLE && token_valid_i && mode[token_i.ep][3:0] == `UEMR_M_DISABLE
    |=> !answer_o.valid)
    else $error("disabled endpoint answered");
  AST_INVALID_SILENT: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RULE12
    state == UEMR_S_DATA && data_done_i && !data_ok |=> !answer_o.valid)
    else $error("invalid data answered");
  AST_STATUS_ACK: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RULE3
    state == UEMR_S_DATA && data_done_i && data_ok && tok == uemr_pkg::UEMR_TOK_OUT &&
    cur_mode == `UEMR_M_ACKI_STO && zero_t1 |=> answer_o.rsp == uemr_pkg::UEMR_RSP_ACK &&
    mode[ep][3:0] == `UEMR_M_NAKI_STO)
    else $error("status out not acked and rewritten");
  AST_SETUP_NAKMODE: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RULE9
    state == UEMR_S_DATA && data_done_i && data_ok && tok == uemr_pkg::UEMR_TOK_SETUP &&
    takes_setup(cur_mode) |=> mode[ep][3:0] == `UEMR_M_NAK_INOUT && answer_o.rsp == uemr_pkg::UEMR_RSP_ACK)
    else $error("setup did not force nak mode");
  AST_ACKIN_REWRITE: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RULE24
    state == UEMR_S_WAIT_HS && host_ack_i && cur_mode == `UEMR_M_ACK_IN |=> mode[ep][3:0] == `UEMR_M_NAK_IN)
    else $error("ack in mode not rewritten");

  // ******************************************
  // rewrites, flags and answers
  // ******************************************
  // rewrites are judged on bits 3:0 only; bit 7 belongs to firmware
  AST_RESET_DISABLED1: assert property (@(posedge clock_i) // RULE10
    !reset_n_i |=> mode[1] == `UEMR_ZERO8)
    else $error("non-control mode not cleared by reset");
  AST_OUT_NAK: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RULE2
    state == UEMR_S_DATA && data_done_i &&
    data_ok && tok == uemr_pkg::UEMR_TOK_OUT &&
    cur_mode == `UEMR_M_NAK_INOUT
    |=> answer_o.valid && answer_o.rsp == uemr_pkg::UEMR_RSP_NAK)
    else $error("mode 0001 did not nak out");
  AST_SETUP_FLAG: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RULE17
    state == UEMR_S_DATA && data_start_i &&
    !ep && tok == uemr_pkg::UEMR_TOK_SETUP &&
    takes_setup(cur_mode)
    |=> status[`UEMR_ST_SETUP] && !status[`UEMR_ST_IN] && !status[`UEMR_ST_OUT])
    else $error("setup status not raised at data start");
  AST_ACKOUT_REWRITE: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RULE23
    state == UEMR_S_DATA && data_done_i &&
    data_ok && tok == uemr_pkg::UEMR_TOK_OUT &&
    cur_mode == `UEMR_M_ACK_OUT && !cur_stall
    |=> answer_o.rsp == uemr_pkg::UEMR_RSP_ACK && mode[ep][3:0] == `UEMR_M_NAK_OUT)
    else $error("ack out mode not rewritten");
  AST_ACKO_REWRITE: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RULE25
    state == UEMR_S_DATA && data_done_i &&
    data_ok && tok == uemr_pkg::UEMR_TOK_OUT &&
    cur_mode == `UEMR_M_ACKO_NAKI
    |=> answer_o.rsp == uemr_pkg::UEMR_RSP_ACK && mode[ep][3:0] == `UEMR_M_NAK_INOUT)
    else $error("ack out nak in mode not rewritten");
  AST_STALL_IN: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RULE22
    state == UEMR_S_IDLE && token_valid_i &&
    token_i.tok == uemr_pkg::UEMR_TOK_IN && token_i.ep &&
    mode[1][3:0] == `UEMR_M_ACK_IN && mode[1][`UEMR_STALL_BIT]
    |=> answer_o.valid && answer_o.rsp == uemr_pkg::UEMR_RSP_STALL)
    else $error("stall bit did not stall in");
  AST_TX0_EMPTY: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RULE5
    state == UEMR_S_IDLE && token_valid_i &&
    token_i.tok == uemr_pkg::UEMR_TOK_IN &&
    mode[token_i.ep][3:0] == `UEMR_M_STS_IN
    |=> answer_o.valid && answer_o.rsp == uemr_pkg::UEMR_RSP_TX0 && answer_o.count == 4'h0)
    else $error("status in did not send an empty packet");
  AST_IN_IGNORED: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RULE15
    state == UEMR_S_IDLE && token_valid_i &&
    token_i.tok == uemr_pkg::UEMR_TOK_IN &&
    mode[token_i.ep][3:0] == `UEMR_M_ACK_OUT
    |=> !answer_o.valid && !irq_o)
    else $error("out-only endpoint answered an in");
  AST_ENGINE_WINS: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RULE26
    state == UEMR_S_WAIT_HS && host_ack_i && ep &&
    cur_mode == `UEMR_M_ACK_IN && reg_wr_i &&
    reg_addr_i == `UEMR_A_MODE1
    |=> mode[1][3:0] == `UEMR_M_NAK_IN)
    else $error("cpu write beat the engine rewrite");
  AST_HS_IRQ: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RULE13
    state == UEMR_S_WAIT_HS && (host_ack_i || host_timeout_i)
    |=> irq_o && state == UEMR_S_IDLE)
    else $error("finished in transfer raised no interrupt");

endmodule

// file: uemr_host_model.sv
`timescale 1ns/10ps
module uemr_host_model (
  // clock
  input  wire logic             clock_i,
  // tokens, data phases and handshakes towards the device
  output logic                  token_valid_o,
  output uemr_pkg::uemr_token_t token_o,
  output logic                  data_start_o,
  output logic                  data_done_o,
  output uemr_pkg::uemr_data_t  data_o,
  output logic                  host_ack_o,
  output logic                  host_timeout_o
);
  initial begin
    token_valid_o = 1'b0;
    token_o = '0;
    data_start_o = 1'b0;
    data_done_o = 1'b0;
    data_o = '0;
    host_ack_o = 1'b0;
    host_timeout_o = 1'b0;
  end
  // ****
  // transfers
  // ****
  // qualifiers are inverted once the strobe drops, so stale values never look valid
  task automatic send_token(input logic ep, input uemr_pkg::uemr_tok_t tok);
    @(posedge clock_i);
    token_valid_o <= 1'b1;
    token_o <= '{ep, tok};
    @(posedge clock_i);
    token_valid_o <= 1'b0;
    token_o <= uemr_pkg::uemr_token_t'(~token_o);
  endtask
  // slow stretches the data phase like a sluggish host
  task automatic send_data(input logic [4:0] cnt, input logic [2:0] f, input int slow);
    @(posedge clock_i);
    data_start_o <= 1'b1;
    @(posedge clock_i);
    data_start_o <= 1'b0;
    repeat (slow) @(posedge clock_i);
    data_done_o <= 1'b1;
    data_o <= '{cnt, f[2], f[1], f[0]};
    @(posedge clock_i);
    data_done_o <= 1'b0;
    data_o <= uemr_pkg::uemr_data_t'(~data_o);
  endtask
  task automatic send_hs(input logic ack);
    @(posedge clock_i);
    host_ack_o <= ack;
    host_timeout_o <= ~ack;
    @(posedge clock_i);
    host_ack_o <= 1'b0;
    host_timeout_o <= 1'b0;
  endtask
endmodule

// file: test_uemr_responder.sv
`timescale 1ns/10ps
`include "uemr_cfg.svh"
module test_uemr_responder;
  // ****
  // signals
  // ****
  localparam uemr_pkg::uemr_tok_t TSU = uemr_pkg::UEMR_TOK_SETUP;
  localparam uemr_pkg::uemr_tok_t TIN = uemr_pkg::UEMR_TOK_IN;
  localparam uemr_pkg::uemr_tok_t TOU = uemr_pkg::UEMR_TOK_OUT;
  localparam uemr_pkg::uemr_rsp_t RNO = uemr_pkg::UEMR_RSP_NONE;
  localparam uemr_pkg::uemr_rsp_t RAK = uemr_pkg::UEMR_RSP_ACK;
  localparam uemr_pkg::uemr_rsp_t RNK = uemr_pkg::UEMR_RSP_NAK;
  localparam uemr_pkg::uemr_rsp_t RST = uemr_pkg::UEMR_RSP_STALL;
  logic                   clock_i;
  logic                   reset_n_i;
  logic [3:0]             reg_addr_i;
  logic [7:0]             reg_wdata_i;
  logic                   reg_wr_i;
  logic                   reg_rd_i;
  logic [7:0]             reg_rdata_o;
  logic                   token_valid_i;
  uemr_pkg::uemr_token_t  token_i;
  logic                   data_start_i;
  logic                   data_done_i;
  uemr_pkg::uemr_data_t   data_i;
  logic                   host_ack_i;
  logic                   host_timeout_i;
  uemr_pkg::uemr_answer_t answer_o;
  logic                   irq_o;
  uemr_pkg::uemr_answer_t ans;
  logic                   irq_seen;
  logic [7:0]             rd_val;
  int                     miscompares = 0;
  int                     checks_done = 0;
  int                     cycles = 0;

  uemr_responder #(.EP_SIZE(8)) uemr_responder_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .token_valid_i(token_valid_i), .token_i(token_i),
    .data_start_i(data_start_i), .data_done_i(data_done_i), .data_i(data_i), .host_ack_i(host_ack_i),
    .host_timeout_i(host_timeout_i), .answer_o(answer_o), .irq_o(irq_o));
  uemr_host_model uemr_host_model_i (.clock_i(clock_i), .token_valid_o(token_valid_i), .token_o(token_i),
    .data_start_o(data_start_i), .data_done_o(data_done_i), .data_o(data_i), .host_ack_o(host_ack_i),
    .host_timeout_o(host_timeout_i));

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      close_out();
    end
  end
  // ****
  // helpers
  // ****
  task automatic close_out();
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    rd_val = reg_rdata_o;
    check("register", rd_val, exp);
  endtask
  // answer and irq are one-cycle pulses, so every cycle of the window is looked at
  task automatic collect();
    ans = '0;
    irq_seen = 1'b0;
    repeat (5) begin
      #1;
      if (answer_o.valid === 1'b1) ans = answer_o;
      if (irq_o === 1'b1) irq_seen = 1'b1;
      @(posedge clock_i);
    end
  endtask
  // f is {toggle, crc good, error checks good}
  task automatic xfer(input logic ep, input uemr_pkg::uemr_tok_t tok, input logic [4:0] cnt, input logic [2:0] f,
                      input uemr_pkg::uemr_rsp_t exp);
    uemr_host_model_i.send_token(ep, tok);
    if (tok != TIN) uemr_host_model_i.send_data(cnt, f, int'(cnt[0]));
    collect();
    check("answer", {5'h00, ans.rsp}, {5'h00, exp});
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    for (int a = 0; a < 4; a++) rd(4'(a), 8'h00);
    xfer(1'b0, TIN, 5'h00, 3'h7, RNO);
    check("irq", {7'h00, irq_seen}, 8'h00);
  endtask
  task automatic t_nak();
    wr(`UEMR_A_MODE0, {4'h0, `UEMR_M_NAK_INOUT});
    xfer(1'b0, TIN, 5'h00, 3'h7, RNK);
    xfer(1'b0, TOU, 5'h04, 3'h7, RNK);
    rd(`UEMR_A_STATUS, 8'h06);
  endtask
  task automatic t_bad();
    wr(`UEMR_A_MODE0, {4'h0, `UEMR_M_STS_OUT});
    xfer(1'b0, TSU, 5'h06, 3'h5, RNO);
    check("corruption irq", {7'h00, irq_seen}, 8'h01);
    xfer(1'b0, TSU, 5'h0B, 3'h7, RNO);
    xfer(1'b0, TSU, 5'h06, 3'h6, RNO);
    rd(`UEMR_A_MODE0, 8'h02);
  endtask
  task automatic t_setup();
    xfer(1'b0, TSU, 5'h0A, 3'h7, RAK);
    check("irq", {7'h00, irq_seen}, 8'h01);
    rd(`UEMR_A_STATUS, 8'h39);
    wr(`UEMR_A_MODE0, 8'h0F);
    rd(`UEMR_A_MODE0, 8'h01);
    wr(`UEMR_A_MODE0, 8'h0F);
    rd(`UEMR_A_MODE0, 8'h0F);
    xfer(1'b0, TOU, 5'h03, 3'h7, RST);
    xfer(1'b0, TOU, 5'h02, 3'h3, RST);
    xfer(1'b0, TOU, 5'h02, 3'h7, RAK);
    rd(`UEMR_A_MODE0, 8'h0E);
  endtask
  task automatic t_modes();
    wr(`UEMR_A_MODE0, {4'h0, `UEMR_M_ACKO_NAKI});
    xfer(1'b0, TOU, 5'h04, 3'h7, RAK);
    rd(`UEMR_A_MODE0, 8'h01);
    wr(`UEMR_A_MODE0, {4'h0, `UEMR_M_STS_IN});
    xfer(1'b0, TIN, 5'h00, 3'h7, uemr_pkg::UEMR_RSP_TX0);
    uemr_host_model_i.send_hs(1'b0);
    wr(`UEMR_A_MODE0, {4'h0, `UEMR_M_IGN_IO});
    xfer(1'b0, TIN, 5'h00, 3'h7, RNO);
  endtask
  // only non-setup modes go to this endpoint
  task automatic t_noncontrol();
    wr(`UEMR_A_CNT1, 8'h05);
    wr(`UEMR_A_MODE1, 8'h0D);
    xfer(1'b1, TIN, 5'h00, 3'h7, uemr_pkg::UEMR_RSP_TXCNT);
    check("tx count", {4'h0, ans.count}, 8'h05);
    fork
      uemr_host_model_i.send_hs(1'b1);
      wr(`UEMR_A_MODE1, 8'h0D);
    join
    collect();
    check("irq", {7'h00, irq_seen}, 8'h01);
    rd(`UEMR_A_MODE1, 8'h0C);
    wr(`UEMR_A_MODE1, 8'h8D);
    xfer(1'b1, TIN, 5'h00, 3'h7, RST);
    wr(`UEMR_A_MODE1, 8'h09);
    xfer(1'b1, TIN, 5'h00, 3'h7, RNO);
    xfer(1'b1, TOU, 5'h04, 3'h7, RAK);
    rd(`UEMR_A_MODE1, 8'h08);
  endtask

  initial begin
    reset_n_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    repeat (4) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_nak();
    t_bad();
    t_setup();
    t_modes();
    t_noncontrol();
    close_out();
  end
endmodule
